// ==== design/drc_clk_div.sv ====
// Purpose: Glitch-free clock enable divider.
// Assumes: Ratio field is 2**div; changes apply only at period end.
// Notes: Shared by the master and MMU clock paths.
`timescale 1ns/1ps
module drc_clk_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [drc_pkg::DIV_W-1:0] div_i,
   input wire logic run_i,
   output logic tick_o
);
   import drc_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [DIV_W-1:0] div_cur;
   logic [DIV_W-1:0] next_div_cur;
   logic next_tick;

   ////////////////////////////////////////////////////////////////
   // The counter steps on domain ticks only, so the ratio holds for either clock source.
   // A new ratio is taken only at a period boundary, so no pulse is cut short.
   always_comb begin
      next_cnt = cnt;
      next_div_cur = div_cur;
      next_tick = 1'b0;
      if (run_i) begin
         if (cnt == CNT_ZERO) begin // [RULE_15]
            next_div_cur = div_i;
            next_tick = 1'b1;
            next_cnt = CNT_W'((1 << div_i) - 1); // [RULE_06] [RULE_08]
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end
   end

   // Registers only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= CNT_ZERO;
         div_cur <= DIV_RST;
         tick_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         div_cur <= next_div_cur;
         tick_o <= next_tick;
      end
   end

   AST_TICK_SPACING: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_15]
      (tick_o && div_cur != DIV_RST) |=> !tick_o)
      else $error("Divided tick came too early.");
endmodule

// ==== design/drc_top.sv ====
// Purpose: Reset, clock enable and idle control of the DSP subsystem.
// Assumes: Control bits come from host registers outside, as plain ports.
// Notes: Clocks are produced as enable pulses on clk_i, never gated clocks.
`timescale 1ns/1ps
module drc_top (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic power_on_reset_pin_i,
   input wire logic host_reset_pin_i,
   input wire logic rtc_power_reset_pin_i,
   input wire logic global_soft_reset_bit_i,
   input wire logic iface_run_bit_i,
   input wire logic core_enable_bit_i,
   input wire logic pll_source_sel_i,
   input wire logic pll_tick_i,
   input wire logic reference_clock_tick_i,
   input wire logic [drc_pkg::DIV_W-1:0] master_clock_divider_i,
   input wire logic master_clock_enable_i,
   input wire logic [drc_pkg::DIV_W-1:0] mmu_clock_divider_i,
   input wire logic mmu_clock_gate_bit_i,
   input wire logic [drc_pkg::DOM_N-1:0] idle_request_i,
   input wire logic idle_apply_i,
   output logic all_modules_rst_o,
   output logic host_rst_o,
   output logic iface_rst_o,
   output logic core_rst_o,
   output logic master_clock_o,
   output logic mmu_clock_o,
   output logic [drc_pkg::DOM_N-1:0] idle_config_o
);
   import drc_pkg::*;

   logic cold;
   logic dom_tick;
   logic m_tick;
   logic u_tick;
   logic next_all;
   logic next_host;
   logic next_iface;
   logic next_core;
   logic next_mclk;
   logic next_uclk;
   logic [DOM_N-1:0] next_idle;

   ////////////////////////////////////////////////////////////////
   // Any cold pin or the global soft reset clears every module.
   assign cold = power_on_reset_pin_i | host_reset_pin_i | rtc_power_reset_pin_i; // [RULE_01]

   // The domain clock follows either the PLL or its reference.
   assign dom_tick = pll_source_sel_i ? pll_tick_i : reference_clock_tick_i; // [RULE_05]

   // Divided master clock; held in its own domain reset by cold or soft reset.
   drc_clk_div u_mdiv (
      .clk_i(clk_i),
      .rst_i(sys_rst_i | next_all),
      .div_i(master_clock_divider_i), // [RULE_06]
      .run_i(dom_tick),
      .tick_o(m_tick)
   );

   // MMU divider shares the domain clock but has its own ratio.
   drc_clk_div u_udiv (
      .clk_i(clk_i),
      .rst_i(sys_rst_i | next_all),
      .div_i(mmu_clock_divider_i), // [RULE_08]
      .run_i(dom_tick),
      .tick_o(u_tick)
   );

   ////////////////////////////////////////////////////////////////
   // Reset and clock outputs. The enable gates whole divided pulses only.
   always_comb begin
      next_all = cold | global_soft_reset_bit_i; // [RULE_01] [RULE_02]
      next_host = global_soft_reset_bit_i; // [RULE_02]
      next_iface = next_all | ~iface_run_bit_i; // [RULE_03]
      next_core = next_all | ~core_enable_bit_i; // [RULE_04] [RULE_12]
      next_mclk = m_tick & master_clock_enable_i; // [RULE_07] [RULE_10] [RULE_15]
      next_uclk = u_tick & ~mmu_clock_gate_bit_i; // [RULE_09]
   end

   // Idle domains: each bit independent; core reset forces all active.
   // Module idle never resets, so state is kept across it.
   always_comb begin
      next_idle = idle_config_o;
      if (next_core) begin
         next_idle = DOM_ACTIVE; // [RULE_12]
      end else if (idle_apply_i) begin
         next_idle = idle_request_i; // [RULE_13] [RULE_14]
      end
   end

   // Registers only; reset asserts every reset but the host reset and clears both clock outputs.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         all_modules_rst_o <= 1'b1;
         host_rst_o <= 1'b0;
         iface_rst_o <= 1'b1;
         core_rst_o <= 1'b1;
         master_clock_o <= 1'b0;
         mmu_clock_o <= 1'b0;
         idle_config_o <= DOM_ACTIVE;
      end else begin
         all_modules_rst_o <= next_all;
         host_rst_o <= next_host;
         iface_rst_o <= next_iface;
         core_rst_o <= next_core;
         master_clock_o <= next_mclk;
         mmu_clock_o <= next_uclk;
         idle_config_o <= next_idle;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks on the reset outputs. Each cause shows one cycle later and leaves with it,
   // since a reset that lingers would stall the core for no reason.

   // Any cold pin resets every module group.
   AST_COLD_RST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
      cold |=> all_modules_rst_o && core_rst_o && iface_rst_o)
      else $error("Cold pin did not reset modules.");

   // Without a cold or soft cause the whole-subsystem reset drops.
   AST_ALL_FREE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
      !next_all |=> !all_modules_rst_o)
      else $error("Subsystem reset stayed without a cause.");

   // The whole-subsystem reset always carries the interface and core resets.
   AST_RST_NEST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
      all_modules_rst_o |-> core_rst_o && iface_rst_o)
      else $error("Subsystem reset without its parts.");

   // A subsystem in reset sees no clock pulse after its first reset cycle, so nothing runs half reset.
   AST_RST_CLK: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
      all_modules_rst_o |=> !master_clock_o && !mmu_clock_o)
      else $error("Clock pulse during subsystem reset.");

   // The global soft reset reaches the host and all modules.
   AST_SOFT_RST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
      global_soft_reset_bit_i |=> host_rst_o && all_modules_rst_o)
      else $error("Soft reset missed.");

   // The host reset follows the soft reset bit alone.
   AST_HOST_FREE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
      !global_soft_reset_bit_i |=> !host_rst_o)
      else $error("Host reset without soft reset.");

   // A cleared interface bit resets the interface modules.
   AST_IFACE_RST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_03]
      !iface_run_bit_i |=> iface_rst_o)
      else $error("Interface reset missed.");

   // A set interface bit with no wider cause lets the interface modules run.
   AST_IFACE_FREE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_03]
      (iface_run_bit_i && !next_all) |=> !iface_rst_o)
      else $error("Interface reset without a cause.");

   // A cleared core enable holds the core but leaves the interface alone.
   AST_CORE_RST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04]
      (!core_enable_bit_i && iface_run_bit_i && !next_all) |=> core_rst_o && !iface_rst_o)
      else $error("Core reset wrong.");

   // A set core enable with no wider cause releases the core.
   AST_CORE_FREE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04]
      (core_enable_bit_i && !next_all) |=> !core_rst_o)
      else $error("Core reset without a cause.");

   ////////////////////////////////////////////////////////////////
   // Checks on the clock pulses. Every pulse must trace back to its own divider.

   // A master pulse only follows a divided tick.
   AST_MCLK_SRC: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_06]
      master_clock_o |-> $past(m_tick))
      else $error("Master pulse without a divided tick.");

   // An enabled divided tick always reaches the modules.
   AST_MCLK_RUN: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_10]
      (m_tick && master_clock_enable_i) |=> master_clock_o)
      else $error("Master pulse lost.");

   // A cleared enable stops the master clock.
   AST_MCLK_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_07]
      !master_clock_enable_i |=> !master_clock_o)
      else $error("Master clock ran while disabled.");

   // An MMU pulse only follows its own divided tick.
   AST_UCLK_SRC: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
      mmu_clock_o |-> $past(u_tick))
      else $error("MMU pulse without a divided tick.");

   // An ungated divided tick always reaches the MMU.
   AST_UCLK_RUN: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
      (u_tick && !mmu_clock_gate_bit_i) |=> mmu_clock_o)
      else $error("MMU pulse lost.");

   // The gate bit stops the MMU clock.
   AST_MMU_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_09]
      mmu_clock_gate_bit_i |=> !mmu_clock_o)
      else $error("MMU clock ran while gated.");

   ////////////////////////////////////////////////////////////////
   // Checks on the idle domains. Subsystem idle loses them; module idle keeps state.

   // Under core reset every domain is active.
   AST_IDLE_RST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
      core_rst_o |-> idle_config_o == DOM_ACTIVE)
      else $error("Idle domains not active under reset.");

   // A request made while the core is held is refused.
   AST_IDLE_REFUSE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
      (next_core && idle_apply_i) |=> idle_config_o == DOM_ACTIVE)
      else $error("Idle request taken during core reset.");

   // An applied request becomes the current configuration.
   AST_IDLE_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_14]
      (!next_core && idle_apply_i) |=> idle_config_o == $past(idle_request_i))
      else $error("Idle configuration not applied.");

   // Module idle never resets anything, so the core keeps its state.
   AST_IDLE_NO_RST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_13]
      (!next_core && idle_apply_i) |=> !core_rst_o && !all_modules_rst_o)
      else $error("Module idle caused a reset.");

   // Each domain holds its state on its own until the next apply or core reset.
   for (genvar g = 0; g < DOM_N; g++) begin : g_dom
      AST_IDLE_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_13]
         (!next_core && !idle_apply_i) |=> $stable(idle_config_o[g]))
         else $error("Idle domain changed without a request.");
   end
endmodule

// ==== shared/drc_pkg.sv ====
// What this block does
// RULE_01: Any cold reset pin resets whole subsystem.
// RULE_02: Global soft reset resets core, host, modules.
// RULE_03: Cleared interface bit resets interface modules.
// RULE_04: Cleared core enable holds non-interface modules reset.
// RULE_05: Clock source selectable: PLL or reference.
// RULE_06: Master clock divider, resets to divide-by-one.
// RULE_07: Master clock enable gates clock, set at reset.
// RULE_08: MMU clock divider, resets to divide-by-one.
// RULE_09: MMU gate bit stops MMU clock.
// RULE_10: Master clock reaches every DSP module.
// RULE_11: Host clears core enable before clock enable.
// RULE_12: Subsystem idle loses state through reset.
// RULE_13: Module-level idle keeps state, no reset.
// RULE_14: Idle domains independent; together form configuration.
// RULE_15: Clock changes never produce short pulses.
//
// Purpose: Constants for the DSP reset, clock and idle controller.
// Assumes: One system clock; clock outputs are one-cycle enables.
// Notes: Divider field holds log2 of the division ratio.
package drc_pkg;
   localparam int DIV_W = 2;
   localparam logic [DIV_W-1:0] DIV_RST = 2'h0;
   localparam int CNT_W = 3;
   localparam int DOM_N = 4;
   localparam logic [DOM_N-1:0] DOM_ACTIVE = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
endpackage

// ==== verif/drc_host_model.sv ====
// Purpose: Host side model that idles the subsystem.
// Assumes: go_idle_i is a level from the bench.
// Notes: The clock enable clears one cycle after the core enable and sets in the same cycle as it.
`timescale 1ns/1ps
module drc_host_model (
   input wire logic clk_i,
   input wire logic go_idle_i,
   output logic core_enable_o,
   output logic master_clock_enable_o
);
   // Reset goes in first, so no core ever runs on a dying clock.
   always @(posedge clk_i) begin
      core_enable_o <= !go_idle_i;
      master_clock_enable_o <= core_enable_o | !go_idle_i;
   end
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the reset, clock and idle controller.
// Assumes: Outputs settle one cycle after their cause.
// Notes: Clock pulses are counted in a window with one pulse of slack for phase, none when zero are expected.
`timescale 1ns/1ps
module tb_top;
   import drc_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, go_idle = 0, en = 1, app = 0;
   logic por = 0, hrst = 0, rtc = 0, sw = 0, run = 1, sel = 1, ptk = 1, rtk = 0, gate = 0;
   logic core_en, mclk_en, all_r, host_r, if_r, core_r, mclk, uclk;
   logic [DIV_W-1:0] mdiv = 2'h0, udiv = 2'h0;
   logic [DOM_N-1:0] ireq = 4'h0, icfg;
   // Inputs por,hrst,rtc,sw,run,en above expected all,host,iface,core.
   logic [9:0] rows [8] = '{10'h030, 10'h23b, 10'h13b, 10'h0bb, 10'h07f, 10'h012, 10'h021,
      10'h003};
   int bad_count = 0, checked = 0, nm, nu;
   drc_host_model i_host (.clk_i(clk_i), .go_idle_i(go_idle), .core_enable_o(core_en),
      .master_clock_enable_o(mclk_en));
   drc_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .power_on_reset_pin_i(por),
      .host_reset_pin_i(hrst), .rtc_power_reset_pin_i(rtc), .global_soft_reset_bit_i(sw),
      .iface_run_bit_i(run), .core_enable_bit_i(core_en & en), .pll_source_sel_i(sel),
      .pll_tick_i(ptk), .reference_clock_tick_i(rtk), .master_clock_divider_i(mdiv),
      .master_clock_enable_i(mclk_en), .mmu_clock_divider_i(udiv),
      .mmu_clock_gate_bit_i(gate), .idle_request_i(ireq), .idle_apply_i(app),
      .all_modules_rst_o(all_r), .host_rst_o(host_r), .iface_rst_o(if_r),
      .core_rst_o(core_r), .master_clock_o(mclk), .mmu_clock_o(uclk), .idle_config_o(icfg));
   // Free-running system clock.
   initial begin
      forever #5 clk_i = !clk_i;
   end
   // Reference source ticks every other cycle.
   always @(posedge clk_i) rtk <= #1 !rtk;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic cmp_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_cnt(input string what, input int exp, input int got);
      checked++;
      if (got > exp + (exp != 0) || got < exp - (exp != 0)) begin
         bad_count++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // Counts pulses on both clock enables, sampled once settled.
   task automatic count(input int n);
      nm = 0;
      nu = 0;
      repeat (n) begin
         cyc(1);
         nm += (mclk === 1'b1);
         nu += (uclk === 1'b1);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // A hang costs a mismatch; the run needs under a thousand cycles.
   initial begin
      #200000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      cyc(20);
      cmp_bits("rst_hold", 4'hb, {all_r, host_r, if_r, core_r});
      sys_rst_i = 0;
      foreach (rows[i]) begin
         {por, hrst, rtc, sw, run, en} = rows[i][9:4];
         cyc(2);
         cmp_bits("rst_row", rows[i][3:0], {all_r, host_r, if_r, core_r});
      end
      run = 1;
      en = 1;
      // The two dividers sweep in opposite directions.
      for (int d = 0; d < 4; d++) begin
         mdiv = d[1:0];
         udiv = 2'(3 - d);
         cyc(20);
         count(64);
         cmp_cnt("master_div", 64 >> d, nm);
         cmp_cnt("mmu_div", 64 >> (3 - d), nu);
      end
      sel = 0;
      gate = 1;
      mdiv = 2'h1;
      cyc(20);
      count(64);
      cmp_cnt("master_ref", 16, nm);
      cmp_cnt("mmu_gated", 0, nu);
      sel = 1;
      gate = 0;
      ireq = 4'ha;
      app = 1;
      cyc(1);
      app = 0;
      cyc(2);
      cmp_bits("idle_cfg", 4'ha, icfg);
      cmp_bits("core_kept", 4'h0, {3'h0, core_r});
      go_idle = 1;
      cyc(4);
      cmp_bits("idle_lost", DOM_ACTIVE, icfg);
      cmp_bits("core_held", 4'h1, {3'h0, core_r});
      // A new idle request is refused while the core is held in reset.
      ireq = 4'h5;
      app = 1;
      cyc(1);
      app = 0;
      cyc(2);
      cmp_bits("idle_refused", DOM_ACTIVE, icfg);
      count(32);
      cmp_cnt("master_off", 0, nm);
      // A second reset in mid-run, then the subsystem is woken again.
      sys_rst_i = 1;
      cyc(3);
      cmp_bits("rst_mid", 4'hb, {all_r, host_r, if_r, core_r});
      cmp_bits("rst_mid_clk", 4'h0, {2'h0, mclk, uclk});
      sys_rst_i = 0;
      go_idle = 0;
      cyc(4);
      cmp_bits("rst_released", 4'h0, {all_r, host_r, if_r, core_r});
      count(16);
      cmp_cnt("master_back", 8, nm);
      cmp_cnt("mmu_back", 16, nu);
      report_and_stop;
   end
endmodule
